// File: wls_defines.svh
// constants for the wavefront lane swizzle datapath
`ifndef WLS_DEFINES_SVH
`define WLS_DEFINES_SVH

`define WLS_FFT_BASE    16'hE000
`define WLS_ROT_BASE    16'hC000
`define WLS_QUAD_BIT    15
`define WLS_ROT_DIR_BIT 10
`define WLS_XOR_LSB     10
`define WLS_OR_LSB      5
`define WLS_AND_LSB     0
`define WLS_ROT_LSB     5
`define WLS_MASK_W      5
`define WLS_HALF_BIT    5
`define WLS_DONE_RST    1'b0

`endif

// File: wls_pkg.sv
// types for the wavefront lane swizzle datapath
`default_nettype none
package wls_pkg;
  typedef enum logic [1:0] {
    WLS_FFT,
    WLS_ROT,
    WLS_QUAD,
    WLS_MAP
  } wls_mode_e;
  typedef logic [15:0] wls_offset_t;
  typedef logic [5:0]  wls_lane_t;
endpackage
`default_nettype wire

// File: wls_lane_swizzle.sv
// cross-lane swizzle datapath for a 64-lane wavefront
`timescale 1ns/10ps
`default_nettype none
`include "wls_defines.svh"

// Function
// - data moves only between lanes; shared memory is never touched.
// - an executing lane whose chosen source lane is invalid receives zero.
// - offset at or above E000 selects FFT mode, mask from bits 4:0.
// - FFT source is reversed low bits shifted by mask ones, half kept.
// - offsets C000 to DFFF rotate by bits 9:5, bit 10 gives direction.
// - rotate keeps own index bits where mask is one, half kept.
// - below C000 bit 15 picks quad sharing, else 32-lane mapping.
// - each quad position takes member chosen by its two offset bits.
// - mapping masks: xor bits 14:10, or bits 9:5, and bits 4:0.
// - mapping source is ((index and mask) or mask) xor mask per half.
// - all 64 lanes are mapped in one single operation.
module wls_lane_swizzle #(
  parameter int LANES  = 64,
  parameter int DATA_W = 32
) (
  input  wire logic                     mclk_in,
  input  wire logic                     reset_in,
  input  wire logic                     op_valid_in,
  input  wire logic [7:0]               offset_low_byte_in,
  input  wire logic [7:0]               offset_high_byte_in,
  input  wire logic [LANES-1:0]         lane_execute_mask_in,
  input  wire logic [LANES*DATA_W-1:0]  lane_data_in,
  output var  logic [LANES*DATA_W-1:0]  result_data_out,
  output var  logic [LANES-1:0]         result_write_out,
  output var  logic                     op_done_out
);
  import wls_pkg::*;

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic wls_mode_e wls_mode(input wls_offset_t off);
    wls_mode_e m;
    if (off >= `WLS_FFT_BASE) begin
      m = WLS_FFT;
    end else if (off >= `WLS_ROT_BASE) begin
      m = WLS_ROT;
    end else if (off[`WLS_QUAD_BIT]) begin
      m = WLS_QUAD;
    end else begin
      m = WLS_MAP;
    end
    return m;
  endfunction

  function automatic logic [4:0] wls_rev5(input logic [4:0] v);
    logic [4:0] r;
    r = 5'h00;
    for (int b = 0; b < 5; b++) begin
      r[b] = v[4-b];
    end
    return r;
  endfunction

  function automatic logic [2:0] wls_ones5(input logic [4:0] v);
    logic [2:0] c;
    c = 3'h0;
    for (int b = 0; b < 5; b++) begin
      c = c + {2'h0, v[b]};
    end
    return c;
  endfunction

  function automatic wls_lane_t wls_src_lane(input wls_lane_t   lane,
                                             input wls_offset_t off);
    logic [4:0] lo;
    logic [4:0] msk;
    logic [4:0] rot;
    logic [4:0] orm;
    logic [4:0] xrm;
    logic [4:0] idx;
    lo  = lane[4:0];
    msk = off[`WLS_AND_LSB +: `WLS_MASK_W];
    rot = off[`WLS_ROT_LSB +: `WLS_MASK_W];
    orm = off[`WLS_OR_LSB +: `WLS_MASK_W];
    xrm = off[`WLS_XOR_LSB +: `WLS_MASK_W];
    idx = 5'h00;
    unique case (wls_mode(off))
      WLS_FFT: begin
        idx = (wls_rev5(lo) >> wls_ones5(msk)) | (lo & msk);
      end
      WLS_ROT: begin
        if (off[`WLS_ROT_DIR_BIT]) begin
          idx = lo - rot;
        end else begin
          idx = lo + rot;
        end
        idx = (lo & msk) | (idx & ~msk);
      end
      WLS_QUAD: begin
        idx = {lo[4:2], off[{lo[1:0], 1'b0} +: 2]};
      end
      WLS_MAP: begin
        idx = ((lo & msk) | orm) ^ xrm;
      end
    endcase
    return {lane[`WLS_HALF_BIT], idx};
  endfunction

  // ----------------------------------------------------------------
  // offset assembly
  // ----------------------------------------------------------------
  wls_offset_t offset_w;
  assign offset_w = {offset_high_byte_in, offset_low_byte_in};

  // ----------------------------------------------------------------
  // per-lane datapath, register sources only
  // ----------------------------------------------------------------
  logic [LANES*DATA_W-1:0] result_ff;
  logic [LANES*DATA_W-1:0] nxt_result;
  wls_lane_t               src_idx [LANES];

  genvar k;
  generate
    for (k = 0; k < LANES; k++) begin : g_lane
      // all lanes evaluated together in one operation
      always_comb begin
        src_idx[k] = wls_src_lane(wls_lane_t'(k), offset_w);
        nxt_result[k*DATA_W +: DATA_W] = result_ff[k*DATA_W +: DATA_W];
        if (op_valid_in && lane_execute_mask_in[k]) begin
          if (lane_execute_mask_in[src_idx[k]]) begin
            nxt_result[k*DATA_W +: DATA_W] =
              lane_data_in[src_idx[k]*DATA_W +: DATA_W];
          end else begin
            nxt_result[k*DATA_W +: DATA_W] = '0;
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      result_ff <= '0;
    end else begin
      result_ff <= nxt_result;
    end
  end

  // ----------------------------------------------------------------
  // completion and write enables
  // ----------------------------------------------------------------
  logic [LANES-1:0] write_ff;
  logic [LANES-1:0] nxt_write;
  logic             done_ff;
  logic             nxt_done;

  always_comb begin
    nxt_done  = op_valid_in;
    nxt_write = op_valid_in ? lane_execute_mask_in : '0;
  end

  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      done_ff  <= `WLS_DONE_RST;
      write_ff <= '0;
    end else begin
      done_ff  <= nxt_done;
      write_ff <= nxt_write;
    end
  end

  assign result_data_out  = result_ff;
  assign result_write_out = write_ff;
  assign op_done_out      = done_ff;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (reset_in);

  sequence issue_s;
    op_valid_in;
  endsequence

  sequence done_once_s;
    op_done_out && result_write_out == $past(lane_execute_mask_in);
  endsequence

  sequence masked_lane0_s;
    op_valid_in && !lane_execute_mask_in[0];
  endsequence

  sequence lane7_live_s;
    op_valid_in && lane_execute_mask_in[7]
      && lane_execute_mask_in[src_idx[7]];
  endsequence

  sequence masked_lane40_s;
    op_valid_in && !lane_execute_mask_in[40];
  endsequence

  property one_cycle_p;
    issue_s |=> done_once_s;
  endproperty

  single_pass_a: assert property (one_cycle_p)
    else $error("swizzle result not one cycle after issue");

  idle_quiet_a: assert property (
    !op_valid_in |=> !op_done_out && result_write_out == '0)
    else $error("write enables raised without an issue");

  hold_disabled_a: assert property (
    masked_lane0_s |=> $stable(result_data_out[DATA_W-1:0]))
    else $error("disabled lane changed its data");

  zero_invalid_a: assert property (
    op_valid_in && lane_execute_mask_in[0]
      && !lane_execute_mask_in[src_idx[0]]
    |=> result_data_out[DATA_W-1:0] == '0)
    else $error("invalid source did not give zero");

  fft_identity_a: assert property (
    op_valid_in && offset_w >= `WLS_FFT_BASE
      && offset_w[4:0] == 5'h1F && lane_execute_mask_in[5]
    |=> result_data_out[5*DATA_W +: DATA_W]
        == $past(lane_data_in[5*DATA_W +: DATA_W]))
    else $error("full fft mask moved data");

  fft_rev_a: assert property (
    offset_w >= `WLS_FFT_BASE && offset_w[4:0] == 5'h00
    |-> src_idx[1] == 6'h10 && src_idx[33] == 6'h30)
    else $error("fft bit reverse wrong");

  rot_left_a: assert property (
    offset_w >= `WLS_ROT_BASE && offset_w < `WLS_FFT_BASE
      && !offset_w[10] && offset_w[4:0] == 5'h00
    |-> src_idx[0] == {1'b0, offset_w[9:5]})
    else $error("left rotate source wrong");

  rot_right_a: assert property (
    offset_w >= `WLS_ROT_BASE && offset_w < `WLS_FFT_BASE
      && offset_w[10] && offset_w[4:0] == 5'h00
    |-> src_idx[32] == {1'b1, 5'h00 - offset_w[9:5]})
    else $error("right rotate source wrong");

  rot_mask_a: assert property (
    offset_w >= `WLS_ROT_BASE && offset_w < `WLS_FFT_BASE
      && offset_w[4:0] == 5'h1F
    |-> src_idx[9] == 6'h09)
    else $error("rotate mask not honoured");

  half_keep_a: assert property (
    src_idx[31][5] == 1'b0 && src_idx[32][5] == 1'b1)
    else $error("source left its lane half");

  quad_pick_a: assert property (
    offset_w < `WLS_ROT_BASE && offset_w[15]
    |-> src_idx[5] == {4'h1, offset_w[3:2]}
        && src_idx[63] == {4'hF, offset_w[7:6]})
    else $error("quad member selection wrong");

  map_mask_a: assert property (
    !offset_w[15]
    |-> src_idx[39] == {1'b1, ((5'h07 & offset_w[4:0])
        | offset_w[9:5]) ^ offset_w[14:10]})
    else $error("32-lane mapping wrong");

  move_data_a: assert property (
    lane7_live_s
    |=> result_data_out[7*DATA_W +: DATA_W]
        == $past(lane_data_in[src_idx[7]*DATA_W +: DATA_W]))
    else $error("enabled lane took wrong source data");

  hold_upper_a: assert property (
    masked_lane40_s |=> $stable(result_data_out[40*DATA_W +: DATA_W]))
    else $error("disabled upper lane changed its data");

  fft_half_mask_a: assert property (
    offset_w >= `WLS_FFT_BASE && offset_w[4:0] == 5'h10
    |-> src_idx[1] == 6'h08 && src_idx[16] == 6'h10)
    else $error("fft partial mask source wrong");

  map_swap_a: assert property (
    offset_w == 16'h401F
    |-> src_idx[3] == 6'h13 && src_idx[50] == 6'h22)
    else $error("sixteen lane swap mapping wrong");

  map_bcast_a: assert property (
    !offset_w[15] && offset_w[14:10] == 5'h00 && offset_w[4:0] == 5'h00
    |-> src_idx[17] == {1'b0, offset_w[9:5]}
        && src_idx[58] == {1'b1, offset_w[9:5]})
    else $error("32-lane broadcast mapping wrong");

  quad_zero_a: assert property (
    op_valid_in && offset_w < `WLS_ROT_BASE && offset_w[15]
      && lane_execute_mask_in[20] && !lane_execute_mask_in[23]
      && offset_w[1:0] == 2'h3
    |=> result_data_out[20*DATA_W +: DATA_W] == '0)
    else $error("quad read of disabled member not zero");

endmodule // wls_lane_swizzle
`default_nettype wire

// File: wls_vreg_model.sv
// vector register file model that takes swizzle results
`timescale 1ns/10ps
`default_nettype none
module wls_vreg_model (
  input  wire logic          mclk_in,
  input  wire logic [2047:0] result_data_in,
  input  wire logic [63:0]   result_write_in,
  output var  logic [2047:0] vreg_out
);
  initial vreg_out = '0;
  // lanes without a write bit keep old contents
  always @(posedge mclk_in) begin
    for (int k = 0; k < 64; k++) begin
      if (result_write_in[k]) begin
        vreg_out[k*32 +: 32] <= result_data_in[k*32 +: 32];
      end
    end
  end
endmodule // wls_vreg_model
`default_nettype wire

// File: wls_lane_swizzle_tb_top.sv
// self-checking bench for the lane swizzle datapath
`timescale 1ns/10ps
`default_nettype none
module wls_lane_swizzle_tb_top;
  import wls_pkg::*;
  logic          clk;
  logic          rst;
  logic          vld;
  wls_offset_t   off;
  logic [63:0]   msk;
  logic [63:0]   wr;
  logic          done;
  logic [2047:0] din;
  logic [2047:0] dout;
  logic [2047:0] vreg;
  logic [2047:0] exp_d;
  int            mismatches;
  int            check_count;

  wls_lane_swizzle u_wls_lane_swizzle (
    .mclk_in             (clk),
    .reset_in            (rst),
    .op_valid_in         (vld),
    .offset_low_byte_in  (off[7:0]),
    .offset_high_byte_in (off[15:8]),
    .lane_execute_mask_in(msk),
    .lane_data_in        (din),
    .result_data_out     (dout),
    .result_write_out    (wr),
    .op_done_out         (done)
  );
  wls_vreg_model u_wls_vreg_model (
    .mclk_in        (clk),
    .result_data_in (dout),
    .result_write_in(wr),
    .vreg_out       (vreg)
  );

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic wls_lane_t src_of(wls_lane_t i, wls_offset_t o);
    logic [4:0] lo;
    logic [4:0] m;
    logic [4:0] r;
    logic [4:0] t;
    lo = i[4:0];
    m = o[4:0];
    r = o[9:5];
    if (o >= 16'hE000) begin
      t = {lo[0], lo[1], lo[2], lo[3], lo[4]} >> $countones(m);
      return {i[5], t | (lo & m)};
    end
    if (o >= 16'hC000) begin
      t = o[10] ? lo - r : lo + r;
      return {i[5], (lo & m) | (t & ~m)};
    end
    if (o[15]) begin
      return {i[5:2], o[2*i[1:0] +: 2]};
    end
    return {i[5], ((lo & m) | r) ^ o[14:10]};
  endfunction

  task automatic chk_data(logic [2047:0] got, logic [2047:0] want);
    check_count++;
    if (got !== want) begin
      mismatches++;
      $display("unexpected lane data at %0t", $time);
    end
  endtask

  task automatic chk_flag(logic [64:0] got, logic [64:0] want);
    check_count++;
    if (got !== want) begin
      mismatches++;
      $display("unexpected done or write %h at %0t", got, $time);
    end
  endtask

  task automatic issue(wls_offset_t o, logic [63:0] m);
    logic [2047:0] nxt;
    wls_lane_t     s;
    nxt = exp_d;
    for (int k = 0; k < 64; k++) begin
      s = src_of(6'(k), o);
      if (m[k]) begin
        nxt[k*32 +: 32] = m[s] ? din[s*32 +: 32] : 32'h0;
      end
    end
    vld = 1'b1;
    off = o;
    msk = m;
    @(negedge clk);
    exp_d = nxt;
    chk_flag({done, wr}, {1'b1, m});
    chk_data(dout, exp_d);
    $display("test offset %h ended", o);
  endtask

  task automatic idle();
    vld = 1'b0;
    @(negedge clk);
    chk_flag({done, wr}, 65'h0);
    chk_data(vreg, exp_d);
  endtask

  task automatic set_data(logic [7:0] seed);
    for (int k = 0; k < 64; k++) begin
      din[k*32 +: 32] = {seed, 16'hC3A5, 8'(k + 1)};
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial begin
    #5000;
    mismatches++;
    complete_run();
  end

  initial begin
    rst = 1'b1;
    vld = 1'b0;
    off = 16'h0000;
    msk = 64'h0;
    din = '0;
    exp_d = '0;
    mismatches = 0;
    check_count = 0;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    set_data(8'h11);
    chk_flag({done, wr}, 65'h0);
    chk_data(dout, exp_d);
    issue(16'hE000, '1);
    issue(16'hE010, '1);
    issue(16'hE01F, '1);
    issue(16'hC020, '1);
    issue(16'hC420, '1);
    issue(16'hC421, '1);
    issue(16'hDFE3, '1);
    issue(16'hC43F, '1);
    idle();
    set_data(8'h22);
    issue(16'hBFFF, '1);
    issue(16'h801B, '1);
    issue(16'h7FFF, '1);
    issue(16'h401F, '1);
    issue(16'h00A0, '1);
    issue(16'h2D6A, '1);
    issue(16'h3E1C, '1);
    idle();
    set_data(8'h33);
    issue(16'h801B, 64'h5A5A_0F0F_3C3C_F007);
    issue(16'h401F, 64'h0000_FFFF_FFFF_0000);
    issue(16'hE008, 64'hFFFF_0000_00FF_FF00);
    issue(16'hC5E1, 64'h3333_CCCC_9999_6666);
    idle();
    complete_run();
  end
endmodule // wls_lane_swizzle_tb_top
`default_nettype wire
